// ===== tcpwm_pkg.sv
// Constants and types for the three-phase complementary PWM generator.
// Assumes a single 50 MHz clock and software-level control on plain ports.
// How it works
// - Run bits low stop and hold counters.
// - Both run bits start counters together.
// - Clear source 000 never clears; edge 00.
// - Mode 1111 transfers buffers at the next crest or trough after a phase-three duty buffer write.
// - Toggle enable toggles carrier pin each half.
// - Inverse select zero gives active low outputs.
// - Positive select zero gives active low outputs.
// - Irq enable passes compare-A flag to request.
// - Upper-limit match occurs once per carrier period.
// - Counters count up then down, lead offset.
// - Duty zero forces positive on; limit forces off.
// - Carrier toggle pin starts at one.
package tcpwm_pkg;
	localparam int          CNT_W         = 16;
	localparam int          CLK_HZ        = 50_000_000;
	localparam int          TICK_HZ       = 10_000_000;
	localparam int          PRESCALE      = (CLK_HZ + TICK_HZ - 1) / TICK_HZ;
	localparam logic [2:0]  PRE_LAST      = 3'(PRESCALE - 1);
	localparam logic [2:0]  CLR_NONE      = 3'h0;
	localparam logic [1:0]  EDGE_RISE     = 2'h0;
	localparam logic [3:0]  MODE_CPWM3    = 4'hF;
	localparam logic [15:0] CNT_RST       = 16'h0000;
	localparam logic [15:0] DEAD_RST      = 16'h0001;
	localparam logic        TOGGLE_RST    = 1'b1;
	typedef enum logic [1:0] {
		TCPWM_IDLE = 2'b00,
		TCPWM_UP   = 2'b01,
		TCPWM_DOWN = 2'b11
	} tcpwm_dir_t;
endpackage

// ===== tcpwm_phase.sv
// One complementary phase: compares duty against both counters.
// Assumes counters and tick come from the parent on the same clock.
`timescale 1ns/10ps
module tcpwm_phase (
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	input  wire logic        run_i,
	input  wire logic        tick_i,
	input  wire logic        pos_lvl_i,
	input  wire logic        inv_lvl_i,
	input  wire logic [15:0] lead_i,
	input  wire logic [15:0] lag_i,
	input  wire logic [15:0] limit_i,
	input  wire logic [15:0] duty_i,
	output logic             pos_o,
	output logic             inv_o
);
	logic pos_on;
	logic inv_on;
	logic pos_ff;
	logic inv_ff;

	// ----------------------------------------
	// Active states from counter compare
	// ----------------------------------------
	always_comb begin
		if (duty_i == tcpwm_pkg::CNT_RST) begin
			pos_on = 1'b1;
			inv_on = 1'b0;
		end else if (duty_i >= limit_i) begin
			pos_on = 1'b0;
			inv_on = 1'b1;
		end else begin
			// Lag counter below duty keeps positive off; lead at or above duty keeps inverse off
			pos_on = (lag_i >= duty_i);
			inv_on = (lead_i < duty_i) && !pos_on;
		end
	end

	// ----------------------------------------
	// Output registers with level select
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			pos_ff <= 1'b0;
			inv_ff <= 1'b0;
		end else if (run_i && tick_i) begin
			pos_ff <= pos_on;
			inv_ff <= inv_on;
		end
	end

	assign pos_o = pos_lvl_i ? pos_ff : !pos_ff;
	assign inv_o = inv_lvl_i ? inv_ff : !inv_ff;
endmodule

// ===== tcpwm_top.sv
// Three-phase complementary PWM top: counters, buffers, flag, toggle pin.
// Assumes software drives the control ports from logic on mclk_i.
`timescale 1ns/10ps
module tcpwm_top (
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	input  wire logic        lead_counter_run_bit_i,
	input  wire logic        lag_counter_run_bit_i,
	input  wire logic [2:0]  counter_clear_source_i,
	input  wire logic [1:0]  count_edge_select_i,
	input  wire logic [3:0]  operating_mode_field_i,
	input  wire logic        carrier_sync_toggle_enable_i,
	input  wire logic        inverse_level_select_i,
	input  wire logic        positive_level_select_i,
	input  wire logic        compare_a_irq_enable_i,
	input  wire logic        compare_a_flag_clear_i,
	input  wire logic        lead_cnt_load_i,
	input  wire logic [15:0] lead_cnt_value_i,
	input  wire logic        lag_cnt_load_i,
	input  wire logic [15:0] lag_cnt_value_i,
	input  wire logic [15:0] dead_time_value_i,
	input  wire logic        half_period_wr_i,
	input  wire logic [15:0] half_period_value_i,
	input  wire logic        half_period_buf_wr_i,
	input  wire logic        upper_limit_wr_i,
	input  wire logic [15:0] upper_limit_value_i,
	input  wire logic        upper_limit_buf_wr_i,
	input  wire logic [2:0]  duty_wr_i,
	input  wire logic [2:0]  duty_buf_wr_i,
	input  wire logic [15:0] duty_value_i,
	output logic [15:0]      lead_updown_counter_o,
	output logic [15:0]      lag_updown_counter_o,
	output logic             compare_a_match_flag_o,
	output logic             compare_a_irq_o,
	output logic             carrier_toggle_pin_o,
	output logic             phase1_positive_pin_o,
	output logic             phase1_inverse_pin_o,
	output logic             phase2_positive_pin_o,
	output logic             phase2_inverse_pin_o,
	output logic             phase3_positive_pin_o,
	output logic             phase3_inverse_pin_o
);
	logic [2:0]            pre_ff;
	logic                  tick;
	logic                  run;
	logic [15:0]           lead_ff;
	logic [15:0]           lag_ff;
	tcpwm_pkg::tcpwm_dir_t dir_ff;
	logic [15:0]           half_ff;
	logic [15:0]           half_buf_ff;
	logic [15:0]           limit_ff;
	logic [15:0]           limit_buf_ff;
	logic [15:0]           duty_ff     [3];
	logic [15:0]           duty_buf_ff [3];
	logic                  armed_ff;
	logic                  flag_ff;
	logic                  toggle_ff;
	logic                  crest;
	logic                  trough;
	logic                  xfer;
	logic                  match;
	logic                  pos_w [3];
	logic                  inv_w [3];

	// ----------------------------------------
	// Prescaler and run control
	// ----------------------------------------
	assign run  = lead_counter_run_bit_i && lag_counter_run_bit_i;
	assign tick = run && (pre_ff == tcpwm_pkg::PRE_LAST) &&
	              (count_edge_select_i == tcpwm_pkg::EDGE_RISE);

	always_ff @(posedge mclk_i) begin
		if (srst_i || !run) begin
			pre_ff <= 3'h0;
		end else if (pre_ff == tcpwm_pkg::PRE_LAST) begin
			pre_ff <= 3'h0;
		end else begin
			pre_ff <= pre_ff + 3'h1;
		end
	end

	// ----------------------------------------
	// Up/down counters
	// ----------------------------------------
	assign crest  = tick && (dir_ff != tcpwm_pkg::TCPWM_DOWN) && (lag_ff >= half_ff);
	// Trough on reaching zero so one carrier period is twice the half period
	assign trough = tick && (dir_ff == tcpwm_pkg::TCPWM_DOWN) && (lag_ff == tcpwm_pkg::CNT_RST);
	assign xfer   = (operating_mode_field_i == tcpwm_pkg::MODE_CPWM3) &&
	                (crest || trough) && armed_ff;
	assign match  = tick && (dir_ff != tcpwm_pkg::TCPWM_DOWN) &&
	                (lead_ff + 16'h0001 == limit_ff);

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			lead_ff <= tcpwm_pkg::CNT_RST;
			lag_ff  <= tcpwm_pkg::CNT_RST;
			dir_ff  <= tcpwm_pkg::TCPWM_IDLE;
		end else if (!run) begin
			// Counters hold while stopped; preload accepted here
			if (lead_cnt_load_i) begin
				lead_ff <= lead_cnt_value_i;
			end
			if (lag_cnt_load_i) begin
				lag_ff <= lag_cnt_value_i;
			end
			dir_ff <= tcpwm_pkg::TCPWM_IDLE;
		end else if (tick) begin
			// Clear source is honoured only as no-clear
			if (crest) begin
				dir_ff  <= tcpwm_pkg::TCPWM_DOWN;
				lead_ff <= lead_ff - 16'h0001;
				lag_ff  <= lag_ff - 16'h0001;
			end else if (trough) begin
				dir_ff  <= tcpwm_pkg::TCPWM_UP;
				lead_ff <= lead_ff + 16'h0001;
				lag_ff  <= lag_ff + 16'h0001;
			end else if (dir_ff == tcpwm_pkg::TCPWM_DOWN) begin
				lead_ff <= lead_ff - 16'h0001;
				lag_ff  <= lag_ff - 16'h0001;
			end else begin
				dir_ff  <= tcpwm_pkg::TCPWM_UP;
				lead_ff <= lead_ff + 16'h0001;
				lag_ff  <= lag_ff + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Period and limit registers with buffers
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			half_ff      <= tcpwm_pkg::CNT_RST;
			half_buf_ff  <= tcpwm_pkg::CNT_RST;
			limit_ff     <= tcpwm_pkg::CNT_RST;
			limit_buf_ff <= tcpwm_pkg::CNT_RST;
		end else begin
			if (half_period_wr_i && !run) begin
				half_ff <= half_period_value_i;
			end else if (xfer) begin
				half_ff <= half_buf_ff;
			end
			if (half_period_buf_wr_i) begin
				half_buf_ff <= half_period_value_i;
			end
			if (upper_limit_wr_i && !run) begin
				limit_ff <= upper_limit_value_i;
			end else if (xfer) begin
				limit_ff <= limit_buf_ff;
			end
			if (upper_limit_buf_wr_i) begin
				limit_buf_ff <= upper_limit_value_i;
			end
		end
	end

	// ----------------------------------------
	// Duty registers; phase-three buffer arms
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			for (int i = 0; i < 3; i++) begin
				duty_ff[i]     <= tcpwm_pkg::CNT_RST;
				duty_buf_ff[i] <= tcpwm_pkg::CNT_RST;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (duty_wr_i[i] && !run) begin
					duty_ff[i] <= duty_value_i;
				end else if (xfer) begin
					duty_ff[i] <= duty_buf_ff[i];
				end
				if (duty_buf_wr_i[i]) begin
					duty_buf_ff[i] <= duty_value_i;
				end
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			armed_ff <= 1'b0;
		end else if (duty_buf_wr_i[2]) begin
			armed_ff <= 1'b1;
		end else if (xfer) begin
			armed_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Upper-limit flag and request
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			flag_ff <= 1'b0;
		end else if (match) begin
			flag_ff <= 1'b1;
		end else if (compare_a_flag_clear_i) begin
			flag_ff <= 1'b0;
		end
	end

	assign compare_a_match_flag_o = flag_ff;
	assign compare_a_irq_o        = flag_ff && compare_a_irq_enable_i;

	// ----------------------------------------
	// Carrier-synchronised toggle pin
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			toggle_ff <= tcpwm_pkg::TOGGLE_RST;
		end else if (carrier_sync_toggle_enable_i && (crest || trough)) begin
			toggle_ff <= !toggle_ff;
		end
	end

	assign carrier_toggle_pin_o  = toggle_ff;
	assign lead_updown_counter_o = lead_ff;
	assign lag_updown_counter_o  = lag_ff;

	// ----------------------------------------
	// Three phases
	// ----------------------------------------
	for (genvar p = 0; p < 3; p++) begin : g_phase
		tcpwm_phase u_phase (
			.mclk_i    (mclk_i),
			.srst_i    (srst_i),
			.run_i     (run),
			.tick_i    (tick),
			.pos_lvl_i (positive_level_select_i),
			.inv_lvl_i (inverse_level_select_i),
			.lead_i    (lead_ff),
			.lag_i     (lag_ff),
			.limit_i   (limit_ff),
			.duty_i    (duty_ff[p]),
			.pos_o     (pos_w[p]),
			.inv_o     (inv_w[p])
		);
	end

	assign phase1_positive_pin_o = pos_w[0];
	assign phase1_inverse_pin_o  = inv_w[0];
	assign phase2_positive_pin_o = pos_w[1];
	assign phase2_inverse_pin_o  = inv_w[1];
	assign phase3_positive_pin_o = pos_w[2];
	assign phase3_inverse_pin_o  = inv_w[2];
endmodule

// ===== tcpwm_chk.sv
// Port-level assertions for the complementary PWM top.
// Assumes a bind onto tcpwm_top and a single mclk_i domain.
`timescale 1ns/10ps
module tcpwm_chk (
	input wire logic        mclk_i,
	input wire logic        srst_i,
	input wire logic        lead_counter_run_bit_i,
	input wire logic        lag_counter_run_bit_i,
	input wire logic        lead_cnt_load_i,
	input wire logic        compare_a_irq_enable_i,
	input wire logic        compare_a_flag_clear_i,
	input wire logic        positive_level_select_i,
	input wire logic        inverse_level_select_i,
	input wire logic [15:0] lead_updown_counter_o,
	input wire logic        compare_a_match_flag_o,
	input wire logic        compare_a_irq_o,
	input wire logic        carrier_toggle_pin_o,
	input wire logic        phase1_positive_pin_o,
	input wire logic        phase1_inverse_pin_o
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	wire logic        run_w = lead_counter_run_bit_i && lag_counter_run_bit_i;
	wire logic [15:0] cnt_w = lead_updown_counter_o;
	wire logic        flg_w = compare_a_match_flag_o;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	a_irq_gate: assert property (compare_a_irq_o == (flg_w && compare_a_irq_enable_i))
		else $error("irq gate wrong");
	a_stop_hold: assert property (!run_w && !$past(run_w) && !lead_cnt_load_i
		|=> $stable(cnt_w)) else $error("count moved while stopped");
	a_step_one: assert property (run_w |=>
		16'(cnt_w - $past(cnt_w)) inside {16'h0000, 16'h0001, 16'hFFFF})
		else $error("count step not one");
	a_tick_gap: assert property (run_w && $changed(cnt_w) |=> !$changed(cnt_w) [*4])
		else $error("ticks too close");
	a_flag_sticky: assert property (flg_w && !compare_a_flag_clear_i |=> flg_w)
		else $error("flag lost");
	a_reset_idle: assert property ($fell(srst_i) |-> carrier_toggle_pin_o && !flg_w
		&& phase1_positive_pin_o != positive_level_select_i) else $error("bad idle");
	a_toggle_run: assert property ($changed(carrier_toggle_pin_o)
		|-> $past(run_w) || $past(run_w, 2)) else $error("toggle while stopped");
	a_pair_excl: assert property (!(phase1_positive_pin_o == positive_level_select_i
		&& phase1_inverse_pin_o == inverse_level_select_i)) else $error("pair overlap");
endmodule

// ===== tcpwm_test.sv
// Self-checking bench for the complementary PWM top.
// Assumes tcpwm_pkg, tcpwm_phase, tcpwm_top and tcpwm_chk compiled first.
`timescale 1ns/10ps
module tcpwm_test;
	localparam logic [15:0] DT  = 16'h0004;
	localparam logic [15:0] HP  = 16'h0028;
	localparam int          PER = 2 * 40 * tcpwm_pkg::PRESCALE;
	logic        mclk_i = 1'b0, srst_i = 1'b1, run3 = 1'b0, run4 = 1'b0, clr = 1'b0;
	logic        tog_en = 1'b1, irq_en = 1'b1, psel = 1'b0, nsel = 1'b0;
	logic [3:0]  mode = tcpwm_pkg::MODE_CPWM3;
	logic [11:0] stb = 12'h000;
	logic [15:0] val = 16'h0000, lead, lag;
	logic [15:0] dead = DT;
	logic        flag, irq, tog, p1p, p1i, p2p, p2i, p3p, p3i;
	logic [1:0]  last = 2'b11;
	int          err_total = 0, check_count = 0, seed = 38;
	int          cnt[6] = '{default: 0};
	// ----------------------------------------
	// Clock, design and waveform counters
	// ----------------------------------------
	always #10 mclk_i = ~mclk_i;
	tcpwm_top dut_u (
		.mclk_i(mclk_i), .srst_i(srst_i), .lead_counter_run_bit_i(run3),
		.lag_counter_run_bit_i(run4), .counter_clear_source_i(tcpwm_pkg::CLR_NONE),
		.count_edge_select_i(tcpwm_pkg::EDGE_RISE), .operating_mode_field_i(mode),
		.carrier_sync_toggle_enable_i(tog_en), .inverse_level_select_i(nsel),
		.positive_level_select_i(psel), .compare_a_irq_enable_i(irq_en),
		.compare_a_flag_clear_i(clr), .lead_cnt_load_i(stb[0]), .lead_cnt_value_i(val),
		.lag_cnt_load_i(stb[1]), .lag_cnt_value_i(val), .dead_time_value_i(dead),
		.half_period_wr_i(stb[2]), .half_period_value_i(val), .half_period_buf_wr_i(stb[3]),
		.upper_limit_wr_i(stb[4]), .upper_limit_value_i(val), .upper_limit_buf_wr_i(stb[5]),
		.duty_wr_i(stb[8:6]), .duty_buf_wr_i(stb[11:9]), .duty_value_i(val),
		.lead_updown_counter_o(lead), .lag_updown_counter_o(lag),
		.compare_a_match_flag_o(flag), .compare_a_irq_o(irq), .carrier_toggle_pin_o(tog),
		.phase1_positive_pin_o(p1p), .phase1_inverse_pin_o(p1i), .phase2_positive_pin_o(p2p),
		.phase2_inverse_pin_o(p2i), .phase3_positive_pin_o(p3p), .phase3_inverse_pin_o(p3i)
	);
	always @(posedge mclk_i) begin
		last <= {p3p, tog};
		cnt[0] <= cnt[0] + int'(tog !== last[0]);
		cnt[1] <= cnt[1] + int'(p3p !== last[1]);
		cnt[2] <= cnt[2] + int'({p1p, p1i} === 2'b01);
		cnt[3] <= cnt[3] + int'({p1p, p1i} === 2'b10);
		cnt[4] <= cnt[4] + int'({p2p, p2i} === 2'b01);
		cnt[5] <= cnt[5] + int'({p2p, p2i} === 2'b10);
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] s, input logic [15:0] v);
		@(posedge mclk_i);
		stb <= s;
		val <= v;
		@(posedge mclk_i);
		stb <= 12'h000;
	endtask
	task automatic wait_flag(output int c);
		c = 0;
		do begin
			@(posedge mclk_i);
			c++;
		end while (flag !== 1'b1 && c < 2000);
		chk(16'(irq), 16'(irq_en));
		clr <= 1'b1;
		@(posedge mclk_i);
		clr <= 1'b0;
	endtask
	// Counts: toggles, phase-three edges, phase one on/off, phase two on/off
	task automatic measure(input int e[6]);
		int c;
		int s0[6];
		wait_flag(c);
		wait_flag(c);
		s0 = cnt;
		wait_flag(c);
		chk(16'(c + 1), 16'(PER));
		for (int i = 0; i < 6; i++) begin
			chk(16'(cnt[i] - s0[i]), 16'(e[i]));
		end
		$display("TB: period test done");
	endtask
	task automatic finish_test();
		$display("TB: checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		int          c;
		logic [15:0] r;
		logic [15:0] hold;
		r = 16'(9 + {$random(seed)} % 26);
		repeat (5) @(posedge mclk_i);
		srst_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		chk(16'({tog, p1p, p1i, p2p, p2i, p3p, p3i}), 16'h007F);
		wr(12'h001, DT);
		wr(12'h002, 16'h0000);
		wr(12'h00C, HP);
		wr(12'h030, HP + DT);
		wr(12'h240, 16'h0000);
		wr(12'h480, HP + DT);
		wr(12'h900, r);
		@(posedge mclk_i);
		run3 <= 1'b1;
		run4 <= 1'b1;
		c = 0;
		do begin
			@(posedge mclk_i);
			c++;
		end while (lead === DT && c < 20);
		chk(lead, DT + 16'h0001);
		chk(lead - lag, DT);
		measure('{2, 2, PER, 0, 0, PER});
		wr(12'h200, HP + DT);
		wr(12'h400, 16'h0000);
		wr(12'h800, r);
		tog_en <= 1'b0;
		irq_en <= 1'b0;
		measure('{0, 2, 0, PER, PER, 0});
		run3 <= 1'b0;
		run4 <= 1'b0;
		repeat (10) @(posedge mclk_i);
		hold = lead;
		repeat (40) @(posedge mclk_i);
		chk(lead, hold);
		psel <= 1'b1;
		nsel <= 1'b1;
		repeat (2) @(posedge mclk_i);
		chk(16'({p1p, p1i}), 16'h0001);
		$display("TB: stop and level test done");
		mode <= 4'h0;
		dead <= 16'h0001;
		wr(12'h001, 16'h0001);
		wr(12'h002, 16'h0000);
		wr(12'h030, HP + 16'h0001);
		wr(12'h200, 16'h0000);
		wr(12'h800, r);
		run3 <= 1'b1;
		run4 <= 1'b1;
		wait_flag(c);
		wait_flag(c);
		chk(16'(c + 1), 16'(PER));
		chk(lead - lag, 16'h0001);
		chk(16'({p1p, p1i}), 16'h0001);
		$display("TB: no dead time and mode test done");
		finish_test();
	end
	initial begin
		repeat (20 * PER) @(posedge mclk_i);
		err_total++;
		finish_test();
	end
endmodule
bind tcpwm_top tcpwm_chk chk_u (.*);
